/* File: flash_host_pkg.sv */
package flash_host_pkg;

	// Clock
	localparam int CLK_PERIOD_NS = 100;

	// Pin timing (least times, rounded up to whole cycles)
	localparam int ADDR_SETUP_NS   = 35;
	localparam int WE_LOW_NS       = 35;
	localparam int DATA_HOLD_NS    = 30;
	localparam int READ_ACCESS_NS  = 110;
	localparam int BUSY_VALID_NS   = 90;
	localparam int RESET_PULSE_MIN_NS = 500;
	localparam int RESET_RECOVER_NS   = 50;

	localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_LOW_CYC     = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_HOLD_CYC  = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_VALID_CYC = (BUSY_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_RECOVER_CYC   = (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int TIMER_W = 8;

	// Flash bus
	localparam int FLASH_AW = 26;
	localparam int FLASH_DW = 16;
	localparam int SECTOR_MSB = 25;
	localparam int SECTOR_LSB = 16;
	localparam logic [9:0]  SECTOR_ZERO    = 10'h000;
	localparam logic [15:0] SW_RESET_DATA  = 16'h00F0;

	// Mode lock register fields
	localparam int LOCK_PWD_BIT  = 2;
	localparam int LOCK_PERS_BIT = 1;
	localparam int LOCK_SEC_BIT  = 0;

	// Status bits returned by the device on a read
	localparam int DQ_TIMING_LIMIT = 5;
	localparam int DQ_BUFFER_ABORT = 1;

	// Register map (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ADDR   = 8'h08;
	localparam logic [7:0] REG_WDATA  = 8'h0C;
	localparam logic [7:0] REG_ADDR2  = 8'h10;
	localparam logic [7:0] REG_WDATA2 = 8'h14;
	localparam logic [7:0] REG_RDATA  = 8'h18;
	localparam logic [7:0] REG_MODE   = 8'h1C;

	// Commands written to CTRL[2:0]
	localparam logic [2:0] CMD_NONE    = 3'h0;
	localparam logic [2:0] CMD_WRITE   = 3'h1;
	localparam logic [2:0] CMD_READ    = 3'h2;
	localparam logic [2:0] CMD_SWRST   = 3'h3;
	localparam logic [2:0] CMD_HWRST   = 3'h4;
	localparam logic [2:0] CMD_PAIR    = 3'h5;
	localparam logic [2:0] CMD_LOCKPGM = 3'h6;

	// STATUS bits
	localparam int ST_BUSY      = 0;
	localparam int ST_DEV_READY = 1;
	localparam int ST_REFUSED   = 2;
	localparam int ST_INTERRUPT = 3;
	localparam int ST_TIMING    = 4;
	localparam int ST_ABORT     = 5;
	localparam int ST_PERS_DONE = 6;
	localparam int ST_PWD_DONE  = 7;

	// MODE bits
	localparam int MODE_SEC0_BLOCK = 0;
	localparam int MODE_PWD_SET    = 1;

	typedef enum logic [8:0] {
		S_IDLE   = 9'h001,
		S_SETUP  = 9'h002,
		S_STROBE = 9'h004,
		S_HOLD   = 9'h008,
		S_RDLOW  = 9'h010,
		S_SETTLE = 9'h020,
		S_RSTLOW = 9'h040,
		S_RSTREC = 9'h080,
		S_SECOND = 9'h100
	} eng_state_t;

endpackage

/* File: flash_wait_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_wait_timer #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	output logic              done
);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (load) begin
			nxt_cnt = loadVal;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - W'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cnt_ff <= '0;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign done = (cnt_ff == '0);

endmodule

`default_nettype wire

/* File: flash_host_ctrl.sv */
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module flash_host_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic             flashCeN,
	output logic             flashWeN,
	output logic             flashOeN,
	output logic             flashResetN,
	output logic [25:0]      flashAddr,
	output logic [15:0]      flashDqOut,
	output logic             flashDqOe,
	input  wire logic [15:0] flashDqIn,
	input  wire logic        readyBusyN
);

	localparam int AW = flash_host_pkg::FLASH_AW;
	localparam int DW = flash_host_pkg::FLASH_DW;
	localparam int TW = flash_host_pkg::TIMER_W;

	// Bus slave state
	logic        dataPhase_ff, nxt_dataPhase;
	logic        wrQ_ff, nxt_wrQ;
	logic [7:0]  offQ_ff, nxt_offQ;
	logic        hreadyout_ff, nxt_hreadyout;
	logic [31:0] hrdata_ff, nxt_hrdata;

	// Software registers
	logic [AW-1:0] addr_ff, nxt_addr;
	logic [DW-1:0] wdata_ff, nxt_wdata;
	logic [AW-1:0] addr2_ff, nxt_addr2;
	logic [DW-1:0] wdata2_ff, nxt_wdata2;
	logic [DW-1:0] rdata_ff, nxt_rdata;
	logic [1:0]    mode_ff, nxt_mode;
	logic [7:0]    status_ff, nxt_status;

	// Engine
	flash_host_pkg::eng_state_t state_ff, nxt_state;
	logic [2:0]    cmd_ff, nxt_cmd;
	logic          ceN_ff, nxt_ceN;
	logic          weN_ff, nxt_weN;
	logic          oeN_ff, nxt_oeN;
	logic          rstN_ff, nxt_rstN;
	logic [AW-1:0] pinAddr_ff, nxt_pinAddr;
	logic [DW-1:0] pinDq_ff, nxt_pinDq;
	logic          dqOe_ff, nxt_dqOe;
	logic          timerLoad;
	logic [TW-1:0] timerVal;
	logic          timerDone;

	flash_wait_timer #(
		.W(TW)
	) u_timer (
		.ref_clk(ref_clk),
		.rst_b  (rst_b),
		.ce     (ce),
		.load   (timerLoad),
		.loadVal(timerVal),
		.done   (timerDone)
	);

	logic       busWr;
	logic [2:0] newCmd;
	logic       cmdOk;
	logic       lockBad;

	always_comb begin
		busWr = dataPhase_ff && wrQ_ff;
		newCmd = flash_host_pkg::CMD_NONE;
		if (busWr && (offQ_ff == flash_host_pkg::REG_CTRL)) begin
			newCmd = hwdata[2:0];
		end
		// Lock program legality
		lockBad = (!wdata_ff[flash_host_pkg::LOCK_PWD_BIT] && !wdata_ff[flash_host_pkg::LOCK_PERS_BIT])
			|| (!wdata_ff[flash_host_pkg::LOCK_PWD_BIT] && status_ff[flash_host_pkg::ST_PERS_DONE])
			|| (!wdata_ff[flash_host_pkg::LOCK_PERS_BIT] && status_ff[flash_host_pkg::ST_PWD_DONE])
			|| (!wdata_ff[flash_host_pkg::LOCK_PWD_BIT] && !mode_ff[flash_host_pkg::MODE_PWD_SET]);
		cmdOk = 1'b1;
		if (newCmd == flash_host_pkg::CMD_LOCKPGM && lockBad) begin
			cmdOk = 1'b0;
		end
		if (newCmd == flash_host_pkg::CMD_SWRST
			&& (!status_ff[flash_host_pkg::ST_DEV_READY] || status_ff[flash_host_pkg::ST_ABORT])) begin
			cmdOk = 1'b0;
		end
		if (newCmd == flash_host_pkg::CMD_READ && mode_ff[flash_host_pkg::MODE_SEC0_BLOCK]
			&& addr_ff[flash_host_pkg::SECTOR_MSB:flash_host_pkg::SECTOR_LSB] == flash_host_pkg::SECTOR_ZERO) begin
			cmdOk = 1'b0;
		end
	end

	always_comb begin
		nxt_dataPhase = 1'b0;
		nxt_wrQ       = wrQ_ff;
		nxt_offQ      = offQ_ff;
		nxt_hreadyout = 1'b1;
		nxt_hrdata    = hrdata_ff;
		nxt_addr      = addr_ff;
		nxt_wdata     = wdata_ff;
		nxt_addr2     = addr2_ff;
		nxt_wdata2    = wdata2_ff;
		nxt_rdata     = rdata_ff;
		nxt_mode      = mode_ff;
		nxt_status    = status_ff;
		nxt_state     = state_ff;
		nxt_cmd       = cmd_ff;
		nxt_ceN       = ceN_ff;
		nxt_weN       = weN_ff;
		nxt_oeN       = oeN_ff;
		nxt_rstN      = rstN_ff;
		nxt_pinAddr   = pinAddr_ff;
		nxt_pinDq     = pinDq_ff;
		nxt_dqOe      = dqOe_ff;
		timerLoad     = 1'b0;
		timerVal      = '0;

		// Address phase accepted, one wait cycle follows
		if (hsel && htrans[1] && hready) begin
			nxt_dataPhase = 1'b1;
			nxt_wrQ       = hwrite;
			nxt_offQ      = haddr[7:0];
			nxt_hreadyout = 1'b0;
		end

		// Status clear by writing ones (hardware set wins, applied below)
		if (busWr) begin
			if (offQ_ff == flash_host_pkg::REG_STATUS) begin
				nxt_status[flash_host_pkg::ST_INTERRUPT:flash_host_pkg::ST_REFUSED] =
					status_ff[flash_host_pkg::ST_INTERRUPT:flash_host_pkg::ST_REFUSED] & ~hwdata[3:2];
				nxt_status[flash_host_pkg::ST_TIMING] = status_ff[flash_host_pkg::ST_TIMING] & ~hwdata[4];
			end else if (offQ_ff == flash_host_pkg::REG_ADDR) begin
				nxt_addr = hwdata[AW-1:0];
			end else if (offQ_ff == flash_host_pkg::REG_WDATA) begin
				nxt_wdata = hwdata[DW-1:0];
			end else if (offQ_ff == flash_host_pkg::REG_ADDR2) begin
				nxt_addr2 = hwdata[AW-1:0];
			end else if (offQ_ff == flash_host_pkg::REG_WDATA2) begin
				nxt_wdata2 = hwdata[DW-1:0];
			end else if (offQ_ff == flash_host_pkg::REG_MODE) begin
				nxt_mode = hwdata[1:0];
			end
		end

		// Read data mux
		if (dataPhase_ff && !wrQ_ff) begin
			if (offQ_ff == flash_host_pkg::REG_CTRL) begin
				nxt_hrdata = {29'h0000000, cmd_ff};
			end else if (offQ_ff == flash_host_pkg::REG_STATUS) begin
				nxt_hrdata = {24'h000000, status_ff};
			end else if (offQ_ff == flash_host_pkg::REG_ADDR) begin
				nxt_hrdata = {6'h00, addr_ff};
			end else if (offQ_ff == flash_host_pkg::REG_WDATA) begin
				nxt_hrdata = {16'h0000, wdata_ff};
			end else if (offQ_ff == flash_host_pkg::REG_ADDR2) begin
				nxt_hrdata = {6'h00, addr2_ff};
			end else if (offQ_ff == flash_host_pkg::REG_WDATA2) begin
				nxt_hrdata = {16'h0000, wdata2_ff};
			end else if (offQ_ff == flash_host_pkg::REG_RDATA) begin
				nxt_hrdata = {16'h0000, rdata_ff};
			end else if (offQ_ff == flash_host_pkg::REG_MODE) begin
				nxt_hrdata = {30'h00000000, mode_ff};
			end else begin
				nxt_hrdata = 32'h00000000;
			end
		end

		// Command launch
		if (newCmd != flash_host_pkg::CMD_NONE) begin
			if (state_ff != flash_host_pkg::S_IDLE || !cmdOk || newCmd == 3'h7) begin
				nxt_status[flash_host_pkg::ST_REFUSED] = 1'b1;
			end else begin
				nxt_cmd = newCmd;
				nxt_status[flash_host_pkg::ST_BUSY] = 1'b1;
				timerLoad = 1'b1;
				if (newCmd == flash_host_pkg::CMD_HWRST) begin
					nxt_state = flash_host_pkg::S_RSTLOW;
					nxt_rstN  = 1'b0;
					nxt_dqOe  = 1'b0;
					timerVal  = TW'(flash_host_pkg::RESET_PULSE_MIN_CYC - 1);
					if (!status_ff[flash_host_pkg::ST_DEV_READY]) begin
						nxt_status[flash_host_pkg::ST_INTERRUPT] = 1'b1;
					end
				end else begin
					nxt_state   = flash_host_pkg::S_SETUP;
					nxt_pinAddr = addr_ff;
					nxt_pinDq   = (newCmd == flash_host_pkg::CMD_SWRST) ? flash_host_pkg::SW_RESET_DATA : wdata_ff;
					nxt_dqOe    = (newCmd != flash_host_pkg::CMD_READ);
					timerVal    = TW'(flash_host_pkg::ADDR_SETUP_CYC - 1);
				end
			end
		end

		case (state_ff)
			flash_host_pkg::S_SETUP: begin
				if (timerDone) begin
					timerLoad = 1'b1;
					nxt_ceN   = 1'b0;
					if (cmd_ff == flash_host_pkg::CMD_READ) begin
						nxt_oeN   = 1'b0;
						nxt_state = flash_host_pkg::S_RDLOW;
						timerVal  = TW'(flash_host_pkg::READ_ACCESS_CYC - 1);
					end else begin
						nxt_weN   = 1'b0;
						nxt_state = flash_host_pkg::S_STROBE;
						timerVal  = TW'(flash_host_pkg::WE_LOW_CYC - 1);
					end
				end
			end
			flash_host_pkg::S_STROBE: begin
				if (timerDone) begin
					nxt_weN   = 1'b1;
					nxt_ceN   = 1'b1;
					nxt_state = flash_host_pkg::S_HOLD;
					timerLoad = 1'b1;
					timerVal  = TW'(flash_host_pkg::DATA_HOLD_CYC - 1);
				end
			end
			flash_host_pkg::S_HOLD: begin
				if (timerDone) begin
					timerLoad = 1'b1;
					if (cmd_ff == flash_host_pkg::CMD_PAIR) begin
						nxt_cmd     = flash_host_pkg::CMD_WRITE;
						nxt_pinAddr = addr2_ff;
						nxt_pinDq   = wdata2_ff;
						nxt_state   = flash_host_pkg::S_SECOND;
						timerVal    = TW'(flash_host_pkg::ADDR_SETUP_CYC - 1);
						nxt_status[flash_host_pkg::ST_ABORT] = 1'b0;
					end else begin
						nxt_dqOe  = 1'b0;
						nxt_state = flash_host_pkg::S_SETTLE;
						timerVal  = TW'(flash_host_pkg::BUSY_VALID_CYC - 1);
					end
				end
			end
			flash_host_pkg::S_SECOND: begin
				if (timerDone) begin
					timerLoad = 1'b1;
					nxt_ceN   = 1'b0;
					nxt_weN   = 1'b0;
					nxt_state = flash_host_pkg::S_STROBE;
					timerVal  = TW'(flash_host_pkg::WE_LOW_CYC - 1);
				end
			end
			flash_host_pkg::S_RDLOW: begin
				if (timerDone) begin
					nxt_rdata = flashDqIn;
					nxt_oeN   = 1'b1;
					nxt_ceN   = 1'b1;
					nxt_state = flash_host_pkg::S_IDLE;
					nxt_status[flash_host_pkg::ST_BUSY] = 1'b0;
					nxt_status[flash_host_pkg::ST_DEV_READY] = readyBusyN;
					if (flashDqIn[flash_host_pkg::DQ_TIMING_LIMIT]) begin
						nxt_status[flash_host_pkg::ST_TIMING] = 1'b1;
					end
					if (flashDqIn[flash_host_pkg::DQ_BUFFER_ABORT] && !readyBusyN) begin
						nxt_status[flash_host_pkg::ST_ABORT] = 1'b1;
					end
				end
			end
			flash_host_pkg::S_SETTLE: begin
				if (timerDone) begin
					nxt_state = flash_host_pkg::S_IDLE;
					nxt_status[flash_host_pkg::ST_BUSY] = 1'b0;
					nxt_status[flash_host_pkg::ST_DEV_READY] = readyBusyN;
					if (cmd_ff == flash_host_pkg::CMD_SWRST) begin
						nxt_status[flash_host_pkg::ST_TIMING] = 1'b0;
					end
					if (cmd_ff == flash_host_pkg::CMD_LOCKPGM) begin
						if (!wdata_ff[flash_host_pkg::LOCK_PWD_BIT]) begin
							nxt_status[flash_host_pkg::ST_PWD_DONE] = 1'b1;
						end
						if (!wdata_ff[flash_host_pkg::LOCK_PERS_BIT]) begin
							nxt_status[flash_host_pkg::ST_PERS_DONE] = 1'b1;
						end
					end
				end
			end
			flash_host_pkg::S_RSTLOW: begin
				if (timerDone) begin
					nxt_rstN  = 1'b1;
					nxt_state = flash_host_pkg::S_RSTREC;
					timerLoad = 1'b1;
					timerVal  = TW'(flash_host_pkg::RESET_RECOVER_CYC - 1);
					nxt_mode[flash_host_pkg::MODE_SEC0_BLOCK] = 1'b0;
				end
			end
			flash_host_pkg::S_RSTREC: begin
				if (timerDone) begin
					nxt_state = flash_host_pkg::S_IDLE;
					nxt_status[flash_host_pkg::ST_BUSY] = 1'b0;
					nxt_status[flash_host_pkg::ST_DEV_READY] = 1'b1;
					nxt_status[flash_host_pkg::ST_ABORT] = 1'b0;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			dataPhase_ff <= 1'b0;
			wrQ_ff       <= 1'b0;
			offQ_ff      <= 8'h00;
			hreadyout_ff <= 1'b1;
			hrdata_ff    <= 32'h00000000;
			addr_ff      <= 26'h0000000;
			wdata_ff     <= 16'hFFFF;
			addr2_ff     <= 26'h0000000;
			wdata2_ff    <= 16'hFFFF;
			rdata_ff     <= 16'h0000;
			mode_ff      <= 2'h0;
			status_ff    <= 8'h02;
			state_ff     <= flash_host_pkg::S_IDLE;
			cmd_ff       <= 3'h0;
			ceN_ff       <= 1'b1;
			weN_ff       <= 1'b1;
			oeN_ff       <= 1'b1;
			rstN_ff      <= 1'b1;
			pinAddr_ff   <= 26'h0000000;
			pinDq_ff     <= 16'h0000;
			dqOe_ff      <= 1'b0;
		end else if (ce) begin
			dataPhase_ff <= nxt_dataPhase;
			wrQ_ff       <= nxt_wrQ;
			offQ_ff      <= nxt_offQ;
			hreadyout_ff <= nxt_hreadyout;
			hrdata_ff    <= nxt_hrdata;
			addr_ff      <= nxt_addr;
			wdata_ff     <= nxt_wdata;
			addr2_ff     <= nxt_addr2;
			wdata2_ff    <= nxt_wdata2;
			rdata_ff     <= nxt_rdata;
			mode_ff      <= nxt_mode;
			status_ff    <= nxt_status;
			state_ff     <= nxt_state;
			cmd_ff       <= nxt_cmd;
			ceN_ff       <= nxt_ceN;
			weN_ff       <= nxt_weN;
			oeN_ff       <= nxt_oeN;
			rstN_ff      <= nxt_rstN;
			pinAddr_ff   <= nxt_pinAddr;
			pinDq_ff     <= nxt_pinDq;
			dqOe_ff      <= nxt_dqOe;
		end
	end

	assign hreadyout   = hreadyout_ff;
	assign hrdata      = hrdata_ff;
	assign hresp       = 1'b0;
	assign flashCeN    = ceN_ff;
	assign flashWeN    = weN_ff;
	assign flashOeN    = oeN_ff;
	assign flashResetN = rstN_ff;
	assign flashAddr   = pinAddr_ff;
	assign flashDqOut  = pinDq_ff;
	assign flashDqOe   = dqOe_ff;

	// Helper: length of the reset pulse
	logic [7:0] rstLowCnt_ff;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rstLowCnt_ff <= 8'h00;
		end else if (ce) begin
			rstLowCnt_ff <= rstN_ff ? 8'h00 : rstLowCnt_ff + 8'h01;
		end
	end

	localparam logic [7:0] RST_MIN = 8'(flash_host_pkg::RESET_PULSE_MIN_CYC);

	a_we_needs_ce: assert property (@(posedge ref_clk) disable iff (!rst_b) !weN_ff |-> !ceN_ff && oeN_ff)
		else $error("write strobe without chip enable or with output enable");
	a_addr_stable_we: assert property (@(posedge ref_clk) disable iff (!rst_b) (!weN_ff && $past(!weN_ff)) |-> $stable(pinAddr_ff) && $stable(pinDq_ff))
		else $error("address or data moved during write strobe");
	a_data_after_rise: assert property (@(posedge ref_clk) disable iff (!rst_b) ($rose(weN_ff) && ce) |-> dqOe_ff && $stable(pinDq_ff))
		else $error("data not held at strobe rise");
	a_rst_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_b) $rose(rstN_ff) |-> $past(rstLowCnt_ff) >= RST_MIN - 8'h01)
		else $error("hardware reset pulse too short");
	a_swrst_data: assert property (@(posedge ref_clk) disable iff (!rst_b) (!weN_ff && cmd_ff == flash_host_pkg::CMD_SWRST) |-> pinDq_ff == flash_host_pkg::SW_RESET_DATA)
		else $error("software reset not sent as 00F0h");
	a_swrst_not_busy: assert property (@(posedge ref_clk) disable iff (!rst_b) (state_ff == flash_host_pkg::S_IDLE && nxt_state == flash_host_pkg::S_SETUP && newCmd == flash_host_pkg::CMD_SWRST) |-> status_ff[flash_host_pkg::ST_DEV_READY] && !status_ff[flash_host_pkg::ST_ABORT])
		else $error("software reset launched while busy or after buffer abort");
	a_lock_both_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) (!weN_ff && cmd_ff == flash_host_pkg::CMD_LOCKPGM) |-> pinDq_ff[flash_host_pkg::LOCK_PWD_BIT] || pinDq_ff[flash_host_pkg::LOCK_PERS_BIT])
		else $error("both mode lock bits programmed together");
	a_sec0_blocked: assert property (@(posedge ref_clk) disable iff (!rst_b) (!oeN_ff && mode_ff[flash_host_pkg::MODE_SEC0_BLOCK] && $past(mode_ff[flash_host_pkg::MODE_SEC0_BLOCK], 8)) |-> pinAddr_ff[flash_host_pkg::SECTOR_MSB:flash_host_pkg::SECTOR_LSB] != flash_host_pkg::SECTOR_ZERO)
		else $error("sector 0 read while blocked");
	a_busy_settle: assert property (@(posedge ref_clk) disable iff (!rst_b) ($rose(weN_ff) && cmd_ff != flash_host_pkg::CMD_PAIR && ce) |-> ##1 status_ff[flash_host_pkg::ST_BUSY])
		else $error("ready sampled before settle time");

endmodule

`default_nettype wire

/* File: flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model (
	input  wire logic        flashCeN,
	input  wire logic        flashWeN,
	input  wire logic        flashOeN,
	input  wire logic        flashResetN,
	input  wire logic [25:0] flashAddr,
	input  wire logic [15:0] flashDqOut,
	input  wire logic        slow,
	output logic [15:0]      flashDqIn,
	output logic             readyBusyN
);
	logic [25:0] capAddr;
	logic [25:0] lastAddr;
	logic [15:0] lastData;
	logic [15:0] lastOut = 16'h0000;
	logic [15:0] rdVal;
	logic        inCyc = 1'b0;
	int          writes = 0;
	int          busyLeft = 0;
	realtime     rstFall = 0.0;
	realtime     rstWidth = 0.0;

	// Address at the later fall of the two strobes
	always @(negedge flashWeN or negedge flashCeN) begin
		#1;
		if (!flashWeN && !flashCeN && flashOeN && flashResetN) begin
			capAddr = flashAddr;
			inCyc = 1'b1;
		end
	end
	// Data at the first rise; reset word ignored while busy
	always @(posedge flashWeN or posedge flashCeN) begin
		if (inCyc && !(flashDqOut === 16'h00F0 && busyLeft != 0)) begin
			lastAddr = capAddr;
			lastData = flashDqOut;
			writes = writes + 1;
			busyLeft = (slow && flashDqOut !== 16'h00F0) ? 40 : 0;
		end
		inCyc = 1'b0;
	end
	always #50 if (busyLeft > 0) busyLeft = busyLeft - 1;
	// Reset aborts the algorithm and drops any half cycle
	always @(negedge flashResetN) begin
		rstFall = $realtime;
		busyLeft = 0;
		inCyc = 1'b0;
	end
	always @(posedge flashResetN) rstWidth = $realtime - rstFall;
	// Sector field in the upper bits; top sector reports both fault flags
	assign rdVal = (flashAddr[15:0] & 16'hFFDD) | ((flashAddr[25:16] == 10'h3FF) ? 16'h0022 : 16'h0000);
	always @(*) if (!flashCeN && !flashOeN && flashResetN) lastOut = rdVal;
	// Released bus shows the inverse of the last value
	assign flashDqIn = (!flashCeN && !flashOeN && flashResetN) ? rdVal : ~lastOut;
	// Open drain with pull-up
	// Top sector also stands for a device stuck in buffer abort
	assign readyBusyN = (busyLeft != 0 || flashAddr[25:16] == 10'h3FF) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        ref_clk, rst_b, hsel, hwrite, hreadyout, hresp, slow;
	logic        flashCeN, flashWeN, flashOeN, flashResetN, flashDqOe, readyBusyN;
	logic [31:0] haddr, hwdata, hrdata, st, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [25:0] flashAddr, a;
	logic [15:0] flashDqOut, flashDqIn, d;
	int          fail_count, checks, w0;

	always #50 ref_clk = ~ref_clk;

	flash_host_ctrl u_dut (
		.ref_clk     (ref_clk),
		.rst_b       (rst_b),
		.ce          (1'b1),
		.hsel        (hsel),
		.haddr       (haddr),
		.htrans      (htrans),
		.hwrite      (hwrite),
		.hsize       (hsize),
		.hwdata      (hwdata),
		.hready      (hreadyout),
		.hreadyout   (hreadyout),
		.hrdata      (hrdata),
		.hresp       (hresp),
		.flashCeN    (flashCeN),
		.flashWeN    (flashWeN),
		.flashOeN    (flashOeN),
		.flashResetN (flashResetN),
		.flashAddr   (flashAddr),
		.flashDqOut  (flashDqOut),
		.flashDqOe   (flashDqOe),
		.flashDqIn   (flashDqIn),
		.readyBusyN  (readyBusyN)
	);

	flash_dev_model u_flash (
		.flashCeN    (flashCeN),
		.flashWeN    (flashWeN),
		.flashOeN    (flashOeN),
		.flashResetN (flashResetN),
		.flashAddr   (flashAddr),
		.flashDqOut  (flashDqOut),
		.slow        (slow),
		.flashDqIn   (flashDqIn),
		.readyBusyN  (readyBusyN)
	);

	function automatic logic [31:0] expRd(input logic [25:0] ad);
		return {16'h0000, ad[15:0] & 16'hFFDD};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, ad};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic cmd(input logic [2:0] c);
		xfer(flash_host_pkg::REG_CTRL, 1'b1, {29'h0, c});
		do begin
			xfer(flash_host_pkg::REG_STATUS, 1'b0, 32'h0);
			st = rd;
		end while (st[flash_host_pkg::ST_BUSY] !== 1'b0);
	endtask

	task automatic lockTry(input logic [15:0] v, input logic expRef);
		w0 = u_flash.writes;
		xfer(flash_host_pkg::REG_STATUS, 1'b1, 32'h00000004);
		xfer(flash_host_pkg::REG_WDATA, 1'b1, {16'h0000, v});
		cmd(flash_host_pkg::CMD_LOCKPGM);
		chk("lock refused", 32'(st[flash_host_pkg::ST_REFUSED]), 32'(expRef));
		chk("lock silent", 32'(u_flash.writes == w0), 32'(expRef));
	endtask

	task automatic summarize();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#2000000;
		fail_count++;
		summarize();
	end

	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		{hsel, hwrite, slow, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		fail_count = 0;
		checks = 0;
		void'($urandom(32'hf699));
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		xfer(flash_host_pkg::REG_STATUS, 1'b0, 32'h0);
		chk("status reset", rd, 32'h00000002);
		xfer(flash_host_pkg::REG_WDATA, 1'b0, 32'h0);
		chk("wdata reset", rd, 32'h0000FFFF);
		xfer(8'h20, 1'b0, 32'h0);
		chk("unmapped", rd, 32'h0);
		for (int i = 0; i < 6; i++) begin
			a = 26'($urandom) & 26'h2FFFFFF;
			d = 16'($urandom) | 16'h0100;
			xfer(flash_host_pkg::REG_ADDR, 1'b1, {6'h00, a});
			xfer(flash_host_pkg::REG_WDATA, 1'b1, {16'h0000, d});
			cmd(flash_host_pkg::CMD_WRITE);
			chk("dev addr", {6'h00, u_flash.lastAddr}, {6'h00, a});
			chk("dev data", {16'h0000, u_flash.lastData}, {16'h0000, d});
			cmd(flash_host_pkg::CMD_READ);
			xfer(flash_host_pkg::REG_RDATA, 1'b0, 32'h0);
			chk("rdata", rd, expRd(a));
		end
		w0 = u_flash.writes;
		cmd(flash_host_pkg::CMD_SWRST);
		chk("swrst data", {16'h0000, u_flash.lastData}, 32'h000000F0);
		chk("swrst count", 32'(u_flash.writes - w0), 32'h1);
		slow <= 1'b1;
		cmd(flash_host_pkg::CMD_WRITE);
		chk("ready low", 32'(st[flash_host_pkg::ST_DEV_READY]), 32'h0);
		w0 = u_flash.writes;
		cmd(flash_host_pkg::CMD_SWRST);
		chk("busy refuse", {st[flash_host_pkg::ST_REFUSED], 31'(u_flash.writes == w0)}, 32'h80000001);
		cmd(flash_host_pkg::CMD_HWRST);
		chk("interrupted", 32'(st[flash_host_pkg::ST_INTERRUPT]), 32'h1);
		chk("pulse", 32'(u_flash.rstWidth >= flash_host_pkg::RESET_PULSE_MIN_NS), 32'h1);
		slow <= 1'b0;
		xfer(flash_host_pkg::REG_STATUS, 1'b1, 32'h0000000C);
		cmd(flash_host_pkg::CMD_READ);
		chk("recovered", st & 32'h0000000E, 32'h00000002);
		xfer(flash_host_pkg::REG_ADDR, 1'b1, 32'h03FF0000);
		cmd(flash_host_pkg::CMD_READ);
		chk("fault flags", st & 32'h00000030, 32'h00000030);
		xfer(flash_host_pkg::REG_ADDR, 1'b1, {6'h00, a});
		cmd(flash_host_pkg::CMD_READ);
		chk("abort held", st & 32'h00000032, 32'h00000032);
		w0 = u_flash.writes;
		cmd(flash_host_pkg::CMD_SWRST);
		chk("abort refuse", {st[flash_host_pkg::ST_REFUSED], 31'(u_flash.writes == w0)}, 32'h80000001);
		xfer(flash_host_pkg::REG_ADDR2, 1'b1, {6'h00, a});
		xfer(flash_host_pkg::REG_WDATA2, 1'b1, {16'h0000, d});
		cmd(flash_host_pkg::CMD_PAIR);
		chk("pair count", 32'(u_flash.writes - w0), 32'h2);
		chk("pair last", {16'h0000, u_flash.lastData}, {16'h0000, d});
		chk("abort clear", 32'(st[flash_host_pkg::ST_ABORT]), 32'h0);
		cmd(flash_host_pkg::CMD_SWRST);
		chk("timing clear", 32'(st[flash_host_pkg::ST_TIMING]), 32'h0);
		xfer(flash_host_pkg::REG_STATUS, 1'b1, 32'h00000004);
		xfer(flash_host_pkg::REG_MODE, 1'b1, 32'h00000001);
		xfer(flash_host_pkg::REG_ADDR, 1'b1, 32'h00000000);
		cmd(flash_host_pkg::CMD_READ);
		chk("sec0 refused", 32'(st[flash_host_pkg::ST_REFUSED]), 32'h1);
		xfer(flash_host_pkg::REG_STATUS, 1'b1, 32'h00000004);
		xfer(flash_host_pkg::REG_ADDR, 1'b1, 32'h00010000);
		cmd(flash_host_pkg::CMD_READ);
		chk("sec1 read", 32'(st[flash_host_pkg::ST_REFUSED]), 32'h0);
		lockTry(16'hFFF9, 1'b1);
		lockTry(16'hFFFB, 1'b1);
		lockTry(16'hFFFD, 1'b0);
		xfer(flash_host_pkg::REG_MODE, 1'b1, 32'h00000003);
		lockTry(16'hFFFB, 1'b1);
		chk("lock state", st & 32'h000000C0, 32'h00000040);
		summarize();
	end
endmodule

`default_nettype wire
